// ==== saas_afe.sv ====
// analog front end model: converter, comparator and slow-mode settling delay
`timescale 1ns/10ps
`default_nettype none

module saas_afe (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // converter inputs
    input wire logic [7:0] convOut,
    input wire logic [7:0] convOe_n,
    // analog level and settling mode
    input wire logic [7:0] vin,
    input wire logic slow,
    // comparator line
    output logic comp
);
    logic now, lag, junk;
    // active high weights, level equals the code
    assign now = (convOut <= vin);
    // slow mode settles one cycle late
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lag <= 1'b0;
            junk <= 1'b0;
        end else begin
            lag <= now;
            junk <= ~junk;
        end
    end
    // floating converter lines give a meaningless comparator
    assign comp = (convOe_n !== 8'h00) ? junk : (slow ? lag : now);
endmodule // saas_afe
`default_nettype wire

// ==== saas_pkg.sv ====
// constants, register map and state encoding for the successive approximation sequencer
//
// Overview of operation
// - port line is input when its direction bit is 0, output when 1
// - control bit 3 one selects data register, zero selects direction register
// - trial code leaves as an 8-bit parallel word on converter port
// - converter bits are active high; one turns the weighted bit on
// - control port: comparator on line 7, request on line 1, outputs elsewhere
// - idle holds finished flag high and waits for cycle request high
// - accepted request clears converter word and bit marker before trials
// - finished flag drops after clearing, showing conversion in progress
// - first trial turns on the most significant bit, half scale
// - comparator low means converter above input: clear bit, else keep
// - set, compare, keep-or-clear repeats for each lower bit
// - one-hot marker shifts right per trial; done when it shifts out
// - wait about 8 us settling after setting each trial bit
// - each trial emits decided bit serially with one simulated clock pulse
// - serial bits go out MSB first, each valid right after comparison
// - keep and clear paths take identical time
// - updated code goes to converter port and readable result register
// - conversion time equals bit time times bit count, input independent
// - after last bit, finished flag rises and sequencer awaits next request
// - full 8-bit conversion takes 700 us
// - simulated clock pulse is 7 us wide
package saas_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] REG_CONV_PORT = 6'h00;
    localparam logic [ADDR_W-1:0] REG_CONV_CTRL = 6'h04;
    localparam logic [ADDR_W-1:0] REG_CTL_PORT = 6'h08;
    localparam logic [ADDR_W-1:0] REG_CTL_CTRL = 6'h0c;
    localparam logic [ADDR_W-1:0] REG_RESULT = 6'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 6'h14;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_SEL_BIT = 3;
    localparam int LINE_COMP = 7;
    localparam int LINE_SC = 5;
    localparam int LINE_CF = 4;
    localparam int LINE_SD = 3;
    localparam int LINE_CYCLE = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_STATE_LSB = 1;
    localparam int STAT_MARK_LSB = 8;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int DOC_BITS = 8;
    localparam int CONV_TIME_NS = 700000;
    localparam int SETTLE_TIME_NS = 8000;
    localparam int PULSE_TIME_NS = 7000;
    localparam int BIT_TIME_NS = CONV_TIME_NS / DOC_BITS;
    // least times round up, the per-bit period rounds down
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 16;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CLEAR = 2'h1,
        ST_TRIAL = 2'h3,
        ST_DONE = 2'h2
    } saas_state_e;

endpackage

// ==== saas_seq_chk.sv ====
// pin-level assertions for the sequencer, bound to every instance
`timescale 1ns/10ps
`default_nettype none

module saas_seq_chk
    import saas_pkg::*;
#(
    parameter int DAC_BITS = 8,
    parameter int BIT_PERIOD = 40,
    parameter int PULSE_WIDTH = 5
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // pins
    input wire logic [DAC_BITS-1:0] convOut,
    input wire logic [DAC_BITS-1:0] convOe_n,
    input wire logic [7:0] ctlOut,
    input wire logic [7:0] ctlOe_n
);
    localparam int LO = DAC_BITS * BIT_PERIOD;
    localparam logic [DAC_BITS-1:0] MSB_ON = {1'b1, {(DAC_BITS-1){1'b0}}};
    logic flag, sc, sd, live, scQ;
    int lowCnt, hiCnt, gap, pulses;
    assign flag = ctlOut[LINE_CF];
    assign sc = ctlOut[LINE_SC];
    assign sd = ctlOut[LINE_SD];
    // pins not yet driven say nothing about the sequencer
    assign live = !ctlOe_n[LINE_CF] && !ctlOe_n[LINE_SC];

    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lowCnt <= 0;
            hiCnt <= 0;
            gap <= 0;
            pulses <= 0;
            scQ <= 1'b0;
        end else begin
            scQ <= sc;
            lowCnt <= flag ? 0 : lowCnt + 1;
            hiCnt <= sc ? hiCnt + 1 : 0;
            gap <= (sc && !scQ) ? 1 : gap + 1;
            pulses <= flag ? 0 : pulses + int'(sc && !scQ);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_dir_gates_out: assert property ((ctlOut & ctlOe_n) == 8'h00)
        else $error("output on an input line");
    a_start_msb: assert property (live && $fell(flag) |-> convOut == MSB_ON)
        else $error("first trial not half scale");
    a_pulse_width: assert property (live && $fell(sc) |-> hiCnt == PULSE_WIDTH)
        else $error("bit clock width wrong");
    a_serial_steady: assert property (live && sc && $past(sc) |-> $stable(sd))
        else $error("serial bit moved under clock");
    a_clock_busy: assert property (live && sc |-> !flag)
        else $error("bit clock while finished");
    a_conv_time: assert property (live && $rose(flag) && $past(live)
        |-> lowCnt >= LO && lowCnt <= LO + 2)
        else $error("conversion length wrong");
    a_bit_count: assert property (live && $rose(flag) && $past(live)
        |-> pulses == DAC_BITS)
        else $error("bit clock count wrong");
    a_bit_period: assert property (live && sc && !scQ && pulses > 0
        |-> gap == BIT_PERIOD)
        else $error("bit period uneven");

    c_start: cover property (live && $fell(flag));
    c_one: cover property (live && $rose(sc) && sd);
    c_zero: cover property (live && $rose(sc) && !sd);
endmodule // saas_seq_chk

bind saas_sequencer saas_seq_chk #(.DAC_BITS(DAC_BITS), .BIT_PERIOD(BIT_PERIOD),
    .PULSE_WIDTH(PULSE_WIDTH)) chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .convOut(convOut), .convOe_n(convOe_n), .ctlOut(ctlOut), .ctlOe_n(ctlOe_n));
`default_nettype wire

// ==== saas_sequencer.sv ====
// successive approximation sequencer with port adapter and AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module saas_sequencer
    import saas_pkg::*;
#(
    parameter int DAC_BITS = DOC_BITS,
    parameter int BIT_PERIOD = BIT_CYCLES,
    parameter int SETTLE_WAIT = SETTLE_CYCLES,
    parameter int PULSE_WIDTH = PULSE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // converter output port pins
    output logic [DAC_BITS-1:0] convOut,
    output logic [DAC_BITS-1:0] convOe_n,
    // control port pins
    input wire logic [7:0] ctlIn,
    output logic [7:0] ctlOut,
    output logic [7:0] ctlOe_n
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (DAC_BITS < 1 || DAC_BITS > 8) begin : g_badBits
        $error("DAC_BITS must be 1 to 8");
    end
    if (SETTLE_WAIT < 1 || PULSE_WIDTH < 1) begin : g_badTimes
        $error("settle and pulse counts must be at least one");
    end
    if (SETTLE_WAIT + PULSE_WIDTH >= BIT_PERIOD || BIT_PERIOD >= (1 << TIMER_W)) begin : g_badPer
        $error("bit period must exceed settle plus pulse and fit the timer");
    end

    localparam logic [TIMER_W-1:0] T_SAMPLE = TIMER_W'(SETTLE_WAIT - 1);
    localparam logic [TIMER_W-1:0] T_PULSE_END = TIMER_W'(SETTLE_WAIT + PULSE_WIDTH - 1);
    localparam logic [TIMER_W-1:0] T_BIT_END = TIMER_W'(BIT_PERIOD - 1);
    localparam logic [DAC_BITS-1:0] MSB_MARK = {1'b1, {(DAC_BITS-1){1'b0}}};

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [7:0] ctlMeta;
    logic [7:0] ctlSync;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctlMeta <= 8'h00;
            ctlSync <= 8'h00;
        end else begin
            ctlMeta <= ctlIn;
            ctlSync <= ctlMeta;
        end
    end

    logic compHigh;
    logic cycleReq;
    assign compHigh = ctlSync[LINE_COMP];
    assign cycleReq = ctlSync[LINE_CYCLE];

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    saas_state_e state;
    logic [TIMER_W-1:0] bitTimer;
    logic [DAC_BITS-1:0] marker;
    logic [DAC_BITS-1:0] code;
    logic [DAC_BITS-1:0] result;
    logic convDone;
    logic serialBit;
    logic bitClock;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cycleReq) begin
                        state <= ST_CLEAR;
                    end
                end
                ST_CLEAR: begin
                    state <= ST_TRIAL;
                end
                ST_TRIAL: begin
                    // marker shifting out ends the run
                    if (bitTimer == T_BIT_END && marker[0]) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // one fixed period per bit whatever the decision
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bitTimer <= '0;
        end else if (state != ST_TRIAL || bitTimer == T_BIT_END) begin
            bitTimer <= '0;
        end else begin
            bitTimer <= bitTimer + 1'b1;
        end
    end

    // one-hot marker, shifted right per trial
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            marker <= '0;
        end else if (state == ST_CLEAR) begin
            marker <= MSB_MARK;
        end else if (state == ST_IDLE && cycleReq) begin
            marker <= '0;
        end else if (state == ST_TRIAL && bitTimer == T_BIT_END) begin
            marker <= marker >> 1;
        end
    end

    // trial code drives the converter word
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            code <= '0;
        end else if (state == ST_IDLE && cycleReq) begin
            code <= '0;
        end else if (state == ST_CLEAR) begin
            code <= MSB_MARK;
        end else if (state == ST_TRIAL) begin
            if (bitTimer == T_SAMPLE && !compHigh) begin
                // converter above input: drop the bit
                code <= code & ~marker;
            end else if (bitTimer == T_BIT_END && !marker[0]) begin
                code <= code | (marker >> 1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            result <= '0;
        end else if (state == ST_TRIAL && bitTimer == T_SAMPLE) begin
            result <= compHigh ? code : (code & ~marker);
        end
    end

    // serial bit valid right after each compare, msb first
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            serialBit <= 1'b0;
        end else if (state == ST_TRIAL && bitTimer == T_SAMPLE) begin
            // one for high, zero for low
            serialBit <= compHigh;
        end
    end

    // pulse high for exactly the pulse count
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bitClock <= 1'b0;
        end else if (state == ST_TRIAL && bitTimer == T_SAMPLE) begin
            bitClock <= 1'b1;
        end else if (bitTimer == T_PULSE_END || state != ST_TRIAL) begin
            bitClock <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            convDone <= 1'b1;
        end else if (state == ST_CLEAR) begin
            convDone <= 1'b0;
        end else if (state == ST_DONE) begin
            convDone <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // port adapter registers
    // ----------------------------------------------------------------
    logic [DAC_BITS-1:0] convDir;
    logic [7:0] convCtrl;
    logic [7:0] ctlDir;
    logic [7:0] ctlData;
    logic [7:0] ctlCtrl;

    logic wrFire;
    logic arFire;
    logic wrOk;
    logic rdOk;
    logic [7:0] wrByte;

    // write needs both channels; taken together, response follows
    assign wrFire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wrFire;
    assign s_axi_wready = wrFire;
    assign arFire = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wrByte = s_axi_wdata[7:0];

    always_comb begin
        case (s_axi_awaddr)
            REG_CONV_PORT, REG_CONV_CTRL, REG_CTL_PORT, REG_CTL_CTRL,
            REG_RESULT, REG_STATUS: wrOk = 1'b1;
            default: wrOk = 1'b0;
        endcase
    end

    // direction written while select is zero, control port data once it is one
    // bit 3 routes the port access
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            convDir <= DAC_BITS'(DIR_RST);
            convCtrl <= CTRL_RST;
            ctlDir <= DIR_RST;
            ctlData <= DATA_RST;
            ctlCtrl <= CTRL_RST;
        end else if (wrFire && s_axi_wstrb[0]) begin
            case (s_axi_awaddr)
                REG_CONV_PORT: begin
                    // data side of the converter port belongs to the sequencer
                    if (!convCtrl[CTRL_SEL_BIT]) begin
                        convDir <= wrByte[DAC_BITS-1:0];
                    end
                end
                REG_CONV_CTRL: begin
                    convCtrl <= wrByte;
                end
                REG_CTL_PORT: begin
                    if (ctlCtrl[CTRL_SEL_BIT]) begin
                        ctlData <= wrByte;
                    end else begin
                        ctlDir <= wrByte;
                    end
                end
                REG_CTL_CTRL: begin
                    ctlCtrl <= wrByte;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control port pin drive
    // ----------------------------------------------------------------
    logic [7:0] lineVal;
    logic [7:0] ctlView;

    for (genvar i = 0; i < 8; i++) begin : g_ctlLine
        if (i == LINE_SC) begin : g_sc
            assign lineVal[i] = bitClock;
        end else if (i == LINE_CF) begin : g_cf
            assign lineVal[i] = convDone;
        end else if (i == LINE_SD) begin : g_sd
            assign lineVal[i] = serialBit;
        end else begin : g_sw
            assign lineVal[i] = ctlData[i];
        end
        assign ctlView[i] = ctlDir[i] ? lineVal[i] : ctlSync[i];
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctlOut <= 8'h00;
            ctlOe_n <= 8'hff;
        end else begin
            ctlOut <= ctlDir & lineVal;
            ctlOe_n <= ~ctlDir;
        end
    end

    // active-high word straight to the converter
    assign convOut = code;
    assign convOe_n = ~convDir;

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [31:0] rdMux;

    always_comb begin
        rdMux = 32'h0000_0000;
        rdOk = 1'b1;
        case (s_axi_araddr)
            REG_CONV_PORT: begin
                rdMux[DAC_BITS-1:0] = convCtrl[CTRL_SEL_BIT] ? code : convDir;
            end
            REG_CONV_CTRL: rdMux[7:0] = convCtrl;
            REG_CTL_PORT: rdMux[7:0] = ctlCtrl[CTRL_SEL_BIT] ? ctlView : ctlDir;
            REG_CTL_CTRL: rdMux[7:0] = ctlCtrl;
            REG_RESULT: rdMux[DAC_BITS-1:0] = result;
            REG_STATUS: begin
                rdMux[STAT_BUSY_BIT] = ~convDone;
                rdMux[STAT_STATE_LSB +: 2] = state;
                rdMux[STAT_MARK_LSB +: DAC_BITS] = marker;
            end
            default: rdOk = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (arFire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // total time is bit count times bit period, fixed
    // default period gives 700 us for 8 bits at this clock

endmodule // saas_sequencer

`default_nettype wire

// ==== saas_tb.sv ====
// self-checking bench for the successive approximation sequencer
`timescale 1ns/10ps
`default_nettype none

module tb;
    import saas_pkg::*;
    localparam int BP = 40;
    localparam int PW = 5;
    logic ref_clk = 1'b0, reset_n = 1'b0, req = 1'b0, slow = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [7:0] vin = 8'h00;
    wire logic awready, wready, bvalid, arready, rvalid, comp;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] convOut, convOe_n, ctlIn, ctlOut, ctlOe_n;
    int nMismatch = 0, compares = 0, cycles = 0, d0, d1;

    // comparator on the top line, request on line one
    assign ctlIn = {comp, 5'h00, req, 1'b0};
    always #5 ref_clk = ~ref_clk;

    saas_sequencer #(.BIT_PERIOD(BP), .SETTLE_WAIT(6), .PULSE_WIDTH(PW)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .convOut(convOut),
        .convOe_n(convOe_n), .ctlIn(ctlIn), .ctlOut(ctlOut), .ctlOe_n(ctlOe_n));
    saas_afe afe (.ref_clk(ref_clk), .reset_n(reset_n), .convOut(convOut),
        .convOe_n(convOe_n), .vin(vin), .slow(slow), .comp(comp));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, nMismatch);
        if (nMismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            nMismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            nMismatch++;
            stop_test();
        end
    end

    // ready and answers are read just after the edge, before the design's flops move
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] d,
        input logic [1:0] er);
        logic [1:0] rs;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge ref_clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
        check("write response", {30'h0, rs}, {30'h0, er});
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        logic [1:0] rs;
        logic [31:0] rd;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        rs = rresp;
        rd = rdata;
        rready <= 1'b0;
        check("read response", {30'h0, rs}, {30'h0, er});
        check("read data", rd, ed);
    endtask

    task automatic wait_pin(input int idx, input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (ctlOut[idx] !== lvl && n < 1000);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_setup();
        axi_read(REG_CONV_PORT, 32'h0, RESP_OKAY);
        axi_read(REG_STATUS, 32'h0, RESP_OKAY);
        check("control enables", {24'h0, ctlOe_n}, 32'hff);
        axi_write(6'h18, 8'hff, RESP_SLVERR);
        axi_read(6'h3c, 32'h0, RESP_SLVERR);
        axi_write(REG_CONV_PORT, 8'hff, RESP_OKAY);
        axi_write(REG_CONV_CTRL, 8'h08, RESP_OKAY);
        axi_write(REG_CTL_PORT, 8'h38, RESP_OKAY);
        axi_write(REG_CTL_CTRL, 8'h08, RESP_OKAY);
        // with select set this lands in data, so enables stay
        axi_write(REG_CTL_PORT, 8'h00, RESP_OKAY);
        axi_read(REG_CTL_CTRL, 32'h08, RESP_OKAY);
        repeat (4) @(posedge ref_clk);
        check("converter enables", {24'h0, convOe_n}, 32'h00);
        check("control enables", {24'h0, ctlOe_n}, 32'hc7);
        check("finished idle", {31'h0, ctlOut[LINE_CF]}, 32'h1);
        $display("test_setup finished");
    endtask

    task automatic test_conv(input logic [7:0] v, input logic s, input logic hold,
        output int dur);
        int n, t0;
        logic [7:0] bits;
        @(posedge ref_clk);
        vin <= v;
        slow <= s;
        req <= 1'b1;
        wait_pin(LINE_CF, 1'b0, n);
        t0 = cycles;
        check("first code", {24'h0, convOut}, 32'h80);
        @(posedge ref_clk);
        req <= hold;
        for (int i = 7; i >= 0; i--) begin
            wait_pin(LINE_SC, 1'b1, n);
            bits[i] = ctlOut[LINE_SD];
            wait_pin(LINE_SC, 1'b0, n);
            check("pulse width", n, PW);
        end
        // a held request clears the word again as the flag rises, so look now
        check("final code", {24'h0, convOut}, {24'h0, v});
        wait_pin(LINE_CF, 1'b1, n);
        dur = cycles - t0;
        check("conversion time", dur, DOC_BITS * BP + 1);
        check("serial bits", {24'h0, bits}, {24'h0, v});
        axi_read(REG_RESULT, {24'h0, v}, RESP_OKAY);
        if (hold) begin
            wait_pin(LINE_CF, 1'b0, n);
            check("restart", n <= 12, 1);
            @(posedge ref_clk);
            req <= 1'b0;
            wait_pin(LINE_CF, 1'b1, n);
        end else begin
            repeat (30) @(posedge ref_clk);
            check("idle flag", {31'h0, ctlOut[LINE_CF]}, 32'h1);
            check("idle code", {24'h0, convOut}, {24'h0, v});
            axi_read(REG_CONV_PORT, {24'h0, v}, RESP_OKAY);
        end
        $display("test_conv %h finished", v);
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        test_setup();
        test_conv(8'h00, 1'b0, 1'b0, d0);
        test_conv(8'hff, 1'b0, 1'b0, d1);
        check("conversion time", d1, d0);
        test_conv(8'ha5, 1'b1, 1'b0, d1);
        check("conversion time", d1, d0);
        test_conv(8'h80, 1'b0, 1'b1, d1);
        check("conversion time", d1, d0);
        stop_test();
    end
endmodule // tb
`default_nettype wire
